// File: src/sarsc_pkg.sv
// constants shared by the converter sequence control block
package sarsc_pkg;
	// register byte addresses on the register bus
	localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
	localparam logic [3:0] ADDR_RESULT_1 = 4'h4;
	localparam logic [3:0] ADDR_RESULT_2 = 4'h8;
	localparam logic [3:0] ADDR_RESULT_3 = 4'hC;
	localparam logic [5:0] ADDR_OPTIONS = 6'h10;
	localparam logic [5:0] ADDR_STOP_CTRL = 6'h14;
	localparam logic [5:0] ADDR_RESULT_4 = 6'h18;
	// control/status field positions
	localparam int CCF_BIT = 7;
	localparam int SCAN_BIT = 5;
	localparam int GROUP_CONVERT_SELECT_BIT = 4;
	// options field positions
	localparam int PWR_BIT = 7;
	localparam int CONVERTER_CLOCK_SELECT_BIT = 6;
	localparam int DLY_BIT = 4;
	localparam int UNIMP_BIT = 2;
	// options bits that software may write (bit 2 kept zero)
	localparam logic [7:0] OPTIONS_WMASK = 8'hFB;
	localparam logic [7:0] OPTIONS_RESET = 8'h10;
	localparam logic [7:0] CTRL_WMASK = 8'h3F;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// channel codes that select reserved sources
	localparam logic [3:0] CH_RES_LO = 4'h8;
	localparam logic [3:0] CH_RES_HI = 4'hB;
	localparam logic [3:0] CH_RES_TOP = 4'hF;
	// conversion timing in bus cycles
	localparam int SAMPLE_CYCLES = 12;
	localparam int BITS = 8;
	localparam int CONV_PER_SEQ = 4;
	// each bit waits out the comparator synchroniser before it is decided
	localparam int SYNC_STAGES = 2;
	localparam int TRIAL_CYCLES = BITS * (SYNC_STAGES + 1);
	// settling and stop-exit figures
	localparam int CLK_HZ = 10000000;
	localparam int PUMP_SETTLE_US = 100;
	localparam int PUMP_SETTLE_CYC = PUMP_SETTLE_US * (CLK_HZ / 1000000);
	localparam int STOP_DELAY_CYC = 4000;
	localparam int STOP_FAST_CYC = 4;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// sequencer states, gray between sample and trial
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_TRIAL = 2'b11,
		ST_HOLD = 2'b10
	} sarsc_state_t;
endpackage

// File: src/sarsc_bit_trial.sv
// bit-trial register: eight msb-first comparisons per conversion
`timescale 1ns/1ps
`default_nettype none
module sarsc_bit_trial #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic start,
	input wire logic step,
	// comparator: high when input is above the trial level
	input wire logic comp_above,
	// trial level to the dac and finished code
	output logic [WIDTH-1:0] trial,
	output logic [WIDTH-1:0] code
);
	logic [WIDTH-1:0] code_q;
	logic [WIDTH-1:0] mask_q;

	// trial level is the decided bits plus the bit under test
	assign trial = code_q | mask_q;
	assign code = code_q;

	// each step keeps or drops the bit under test, then moves one lower
	always_ff @(posedge aclk)
	begin
		if (!aresetn || start)
		begin
			code_q <= '0;
			mask_q <= {1'b1, {(WIDTH-1){1'b0}}};
		end
		else if (step)
		begin
			if (comp_above)
				code_q <= code_q | mask_q; // clamps at all ones
			mask_q <= mask_q >> 1;
		end
	end
endmodule
`default_nettype wire

// File: src/sarsc_delay.sv
// settle counter: busy for a loaded number of cycles
`timescale 1ns/1ps
`default_nettype none
module sarsc_delay #(
	parameter int WIDTH = 13
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// load a count, counts down to zero
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic busy
);
	logic [WIDTH-1:0] cnt_q;

	assign busy = (cnt_q != '0);

	// a fresh load restarts the wait
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= count;
		else if (busy)
			cnt_q <= cnt_q - 1'b1;
	end
endmodule
`default_nettype wire

// File: src/sarsc_top.sv
// converter sequence control with an axi4-lite register slave
// Operation
// - eight msb-first comparisons per conversion
// - copy bit-trial code to assigned result
// - charge pump on only while powered up
// - four readable 8-bit result registers
// - results update only outside read cycles (here a copy may land on the same edge as a read capture)
// - clock select: 0 bus, 1 rc
// - groups of four, once or repeating
// - complete flag after fourth conversion
// - options bit 7 is power-up
// - stop exit: 4000 cycles or four
// - options bit 2 reads zero
// - sequence starts one cycle after write
// - low ref 00, high FF, clamps
// - sixteen sources, some codes reserved
// - group position selects result register
// - sample switch closed twelve cycles only
// - control write clears flag, restarts
// - scan repeats with rotation, else halts
// - single channel four times, or group
// - group mode ignores two low bits
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sarsc_top #(
	parameter int STOP_DELAY = sarsc_pkg::STOP_DELAY_CYC,
	parameter int PUMP_SETTLE = sarsc_pkg::PUMP_SETTLE_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog front end
	input wire logic comp_above,
	output logic [3:0] mux_select,
	output logic sample_switch,
	output logic [7:0] dac_trial,
	output logic charge_pump_en,
	output logic rc_clock_select,
	// stop mode
	input wire logic stop_mode,
	output logic conv_ready
);
	// comparator and stop come from the analog side: two flops each
	logic comp_s1_q, comp_s2_q, stop_s1_q, stop_s2_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
		end
		else
		begin
			comp_s1_q <= comp_above;
			comp_s2_q <= comp_s1_q;
			stop_s1_q <= stop_mode;
			stop_s2_q <= stop_s1_q;
		end
	end

	// register state
	logic [7:0] ctrl_q, opt_q;
	logic ccf_q;
	logic [7:0] result_q [sarsc_pkg::CONV_PER_SEQ];

	// write channel capture: address and data may come in either order
	logic aw_have_q, w_have_q;
	logic [5:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic wr_fire;
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;

	// address decode helpers
	function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] r);
		addr_hit = (a[5:2] == r[5:2]);
	endfunction
	logic wr_ctrl, wr_opt, wr_known;
	assign wr_ctrl = wr_fire && addr_hit(aw_addr_q, 6'(sarsc_pkg::ADDR_CTRL_STATUS))
		&& w_strb_q[0];
	assign wr_opt = wr_fire && addr_hit(aw_addr_q, sarsc_pkg::ADDR_OPTIONS)
		&& w_strb_q[0];
	// results are read-only; writes to them are accepted and ignored
	assign wr_known = addr_hit(aw_addr_q, 6'(sarsc_pkg::ADDR_CTRL_STATUS))
		|| addr_hit(aw_addr_q, sarsc_pkg::ADDR_OPTIONS)
		|| addr_hit(aw_addr_q, 6'(sarsc_pkg::ADDR_RESULT_1))
		|| addr_hit(aw_addr_q, 6'(sarsc_pkg::ADDR_RESULT_2))
		|| addr_hit(aw_addr_q, 6'(sarsc_pkg::ADDR_RESULT_3))
		|| addr_hit(aw_addr_q, sarsc_pkg::ADDR_RESULT_4);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			s_axi_bresp <= sarsc_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				s_axi_bresp <= wr_known ? sarsc_pkg::RESP_OKAY
					: sarsc_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// read channel: one-cycle answer, data held until taken
	logic rvalid_q;
	logic [31:0] rd_word;
	logic rd_known;
	logic rd_fire;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_comb
	begin
		rd_word = '0;
		rd_known = 1'b1;
		if (addr_hit(s_axi_araddr, 6'(sarsc_pkg::ADDR_CTRL_STATUS)))
			rd_word[7:0] = {ccf_q, 1'b0, ctrl_q[5:0]};
		else if (addr_hit(s_axi_araddr, 6'(sarsc_pkg::ADDR_RESULT_1)))
			rd_word[7:0] = result_q[0];
		else if (addr_hit(s_axi_araddr, 6'(sarsc_pkg::ADDR_RESULT_2)))
			rd_word[7:0] = result_q[1];
		else if (addr_hit(s_axi_araddr, 6'(sarsc_pkg::ADDR_RESULT_3)))
			rd_word[7:0] = result_q[2];
		else if (addr_hit(s_axi_araddr, sarsc_pkg::ADDR_RESULT_4))
			rd_word[7:0] = result_q[3];
		else if (addr_hit(s_axi_araddr, sarsc_pkg::ADDR_OPTIONS))
			rd_word[7:0] = opt_q & sarsc_pkg::OPTIONS_WMASK;
		else if (addr_hit(s_axi_araddr, sarsc_pkg::ADDR_STOP_CTRL))
			rd_word[0] = conv_ready;
		else
			rd_known = 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= sarsc_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? sarsc_pkg::RESP_OKAY
				: sarsc_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// options and control registers; options bit 2 never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			opt_q <= sarsc_pkg::OPTIONS_RESET;
			ctrl_q <= sarsc_pkg::CTRL_RESET;
		end
		else
		begin
			if (wr_opt)
				opt_q <= w_data_q[7:0] & sarsc_pkg::OPTIONS_WMASK;
			if (wr_ctrl)
				ctrl_q <= w_data_q[7:0] & sarsc_pkg::CTRL_WMASK;
		end
	end

	// power, pump and clock select straight from the options register
	logic powered;
	assign powered = opt_q[sarsc_pkg::PWR_BIT];
	assign charge_pump_en = powered;
	assign rc_clock_select = opt_q[sarsc_pkg::CONVERTER_CLOCK_SELECT_BIT];

	// pump settling after power-up and restart hold after stop
	logic pwr_prev_q, stop_prev_q, pump_busy, stop_busy;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwr_prev_q <= 1'b0;
			stop_prev_q <= 1'b0;
		end
		else
		begin
			pwr_prev_q <= powered;
			stop_prev_q <= stop_s2_q;
		end
	end
	sarsc_delay #(.WIDTH(13)) u_pump_wait (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(powered && !pwr_prev_q),
		.count(13'(PUMP_SETTLE)),
		.busy(pump_busy)
	);
	sarsc_delay #(.WIDTH(13)) u_stop_wait (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(stop_prev_q && !stop_s2_q),
		.count(opt_q[sarsc_pkg::DLY_BIT] ? 13'(STOP_DELAY)
			: 13'(sarsc_pkg::STOP_FAST_CYC)),
		.busy(stop_busy)
	);
	// the previous-value flops cover the cycle before each counter loads,
	// so ready never shows high for one cycle at power-up or stop exit
	logic halted;
	assign halted = stop_s2_q || stop_prev_q || stop_busy;
	assign conv_ready = powered && pwr_prev_q && !pump_busy && !halted;

	// sequencer
	sarsc_pkg::sarsc_state_t state_q, state_d;
	logic [4:0] cyc_q;
	logic [1:0] slot_q;
	logic [1:0] ph_q;
	logic start_q, step;
	logic [7:0] code;
	logic scan, group_convert_select;
	assign scan = ctrl_q[sarsc_pkg::SCAN_BIT];
	assign group_convert_select = ctrl_q[sarsc_pkg::GROUP_CONVERT_SELECT_BIT];

	// group mode takes the two high bits and the slot as low bits
	assign mux_select = group_convert_select ? {ctrl_q[3:2], slot_q}
		: ctrl_q[3:0];
	assign sample_switch = (state_q == sarsc_pkg::ST_SAMPLE) && !halted
		&& powered;

	logic sample_done, trial_done, conv_done;
	assign sample_done = cyc_q == 5'(sarsc_pkg::SAMPLE_CYCLES - 1);
	assign trial_done = cyc_q == 5'(sarsc_pkg::TRIAL_CYCLES - 1);
	// a bit is decided only once its trial level has crossed the sync flops
	assign step = state_q == sarsc_pkg::ST_TRIAL
		&& ph_q == 2'(sarsc_pkg::SYNC_STAGES);
	assign conv_done = state_q == sarsc_pkg::ST_TRIAL && trial_done && !halted;

	// next state; stop suspends the current channel, which is resampled
	always_comb
	begin
		case (state_q)
			sarsc_pkg::ST_IDLE: state_d = sarsc_pkg::ST_IDLE;
			sarsc_pkg::ST_SAMPLE: state_d = sample_done ? sarsc_pkg::ST_TRIAL
				: sarsc_pkg::ST_SAMPLE;
			sarsc_pkg::ST_TRIAL: state_d = !trial_done ? sarsc_pkg::ST_TRIAL
				: (slot_q == 2'(sarsc_pkg::CONV_PER_SEQ - 1) && !scan)
				? sarsc_pkg::ST_IDLE : sarsc_pkg::ST_SAMPLE;
			sarsc_pkg::ST_HOLD: state_d = sarsc_pkg::ST_SAMPLE;
			default: state_d = sarsc_pkg::ST_IDLE;
		endcase
	end

	// trial phase: one decision every sync depth plus one cycles
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_q != sarsc_pkg::ST_TRIAL || step)
			ph_q <= '0;
		else
			ph_q <= ph_q + 2'h1;
	end

	// start is registered so sampling begins one cycle after the write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= sarsc_pkg::ST_IDLE;
			cyc_q <= '0;
			slot_q <= '0;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= wr_ctrl;
			if (wr_ctrl)
			begin
				state_q <= sarsc_pkg::ST_HOLD;
				cyc_q <= '0;
				slot_q <= '0;
			end
			else if (start_q || !powered)
			begin
				state_q <= powered ? sarsc_pkg::ST_SAMPLE : sarsc_pkg::ST_IDLE;
				cyc_q <= '0;
			end
			else if (halted && state_q != sarsc_pkg::ST_IDLE)
			begin
				state_q <= sarsc_pkg::ST_SAMPLE;
				cyc_q <= '0;
			end
			else
			begin
				state_q <= state_d;
				// fixed 12 + 24 cycles per conversion
				if (state_d != state_q)
					cyc_q <= '0;
				else
					cyc_q <= cyc_q + 5'h01;
				if (conv_done)
					slot_q <= slot_q + 2'h1; // rotates in scan
			end
		end
	end

	sarsc_bit_trial #(.WIDTH(sarsc_pkg::BITS)) u_trial (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(state_q != sarsc_pkg::ST_TRIAL || halted),
		.step(step),
		.comp_above(comp_s2_q),
		.trial(dac_trial),
		.code(code)
	);

	// final bit folds into the code at the copy
	logic [7:0] final_code;
	assign final_code = comp_s2_q ? (code | 8'h01) : code;

	// result copy and read capture share the same rising clock edge:
	// the read captures rd_word from before the copy, so a copy never tears a read
	genvar gi;
	generate
		for (gi = 0; gi < sarsc_pkg::CONV_PER_SEQ; gi++)
		begin : g_res
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					result_q[gi] <= '0;
				else if (conv_done && slot_q == 2'(gi))
					result_q[gi] <= final_code;
			end
		end
	endgenerate

	// flag: set wins over the clear when both land together
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ccf_q <= 1'b0;
		else if (conv_done && slot_q == 2'(sarsc_pkg::CONV_PER_SEQ - 1))
			ccf_q <= 1'b1;
		else if (wr_ctrl)
			ccf_q <= 1'b0;
	end
endmodule
`default_nettype wire

// File: sim/sarsc_analog_model.sv
// analog front end model: sixteen source levels and the comparator
`timescale 1ns/1ps
`default_nettype none
module sarsc_analog_model (
	// source levels and the selected channel
	input wire logic [15:0][7:0] levels,
	input wire logic [3:0] mux_select,
	// trial level from the converter
	input wire logic [7:0] dac_trial,
	output logic comp_above
);
	// each source sits half a step above its code, so a tie keeps the bit
	assign comp_above = levels[mux_select] >= dac_trial;
endmodule
`default_nettype wire

// File: sim/sarsc_sva.sv
// assertion checker for the converter sequence control ports
`timescale 1ns/1ps
`default_nettype none
module sarsc_sva #(
	parameter int STOP_DELAY = 20,
	parameter int PUMP_SETTLE = 10
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog front end
	input wire logic sample_switch,
	input wire logic [7:0] dac_trial,
	input wire logic charge_pump_en,
	input wire logic conv_ready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	localparam int WIN = sarsc_pkg::SAMPLE_CYCLES;
	// consecutive cycles with the sample switch closed
	logic [4:0] samp_cnt_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !sample_switch)
			samp_cnt_q <= '0;
		else
			samp_cnt_q <= samp_cnt_q + 5'h01;
	end
	// switch opens exactly when the window count is reached
	sequence sample_win;
		!sample_switch && samp_cnt_q == 5'(WIN);
	endsequence
	a_sample_twelve: assert property ($fell(sample_switch) |-> sample_win)
		else $error("sample window length wrong");
	a_sample_bound: assert property (sample_switch |-> samp_cnt_q < 5'(WIN))
		else $error("sample window too long");
	a_trial_msb_first: assert property ($fell(sample_switch) |-> ##[0:1] dac_trial == 8'h80)
		else $error("first trial is not the top bit");
	a_sample_powered: assert property (sample_switch |-> charge_pump_en)
		else $error("sampling while powered down");
	a_ready_needs_pump: assert property (!charge_pump_en |-> !conv_ready)
		else $error("ready without pump");
	// settle time is PUMP_SETTLE cycles, at least eight in this bench
	a_pump_settle: assert property ($rose(charge_pump_en) |-> !conv_ready [*8])
		else $error("ready before pump settled");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
endmodule
bind sarsc_top sarsc_sva #(.STOP_DELAY(STOP_DELAY), .PUMP_SETTLE(PUMP_SETTLE)) u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.sample_switch(sample_switch), .dac_trial(dac_trial),
	.charge_pump_en(charge_pump_en), .conv_ready(conv_ready));
`default_nettype wire

// File: sim/sar_adc_sequence_control_bench.sv
// self-checking bench for the converter sequence control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequence_control_bench;
	localparam logic [5:0] A_CTRL = {2'b00, sarsc_pkg::ADDR_CTRL_STATUS};
	localparam logic [5:0] A_OPT = sarsc_pkg::ADDR_OPTIONS;
	localparam logic [5:0] A_STAT = sarsc_pkg::ADDR_STOP_CTRL;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode;
	logic awready, wready, bvalid, arready, rvalid, comp_above;
	logic sample_switch, charge_pump_en, rc_clock_select, conv_ready;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_q;
	logic [1:0] bresp, rresp, resp_q;
	logic [3:0] mux_select;
	logic [7:0] dac_trial;
	logic [15:0][7:0] lv;
	logic [5:0] ra [4];
	int error_cnt, tests_run, g;
	// short settle counts keep the run brief
	sarsc_top #(.STOP_DELAY(20), .PUMP_SETTLE(10)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .comp_above(comp_above),
		.mux_select(mux_select), .sample_switch(sample_switch),
		.dac_trial(dac_trial), .charge_pump_en(charge_pump_en),
		.rc_clock_select(rc_clock_select), .stop_mode(stop_mode),
		.conv_ready(conv_ready));
	sarsc_analog_model model (.levels(lv), .mux_select(mux_select),
		.dac_trial(dac_trial), .comp_above(comp_above));
	// 100 ns clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a lost handshake ends the run
	task automatic hang(input string nm);
		error_cnt++;
		$display("BAD %s expected answer seen timeout", nm);
		final_report();
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				resp_q = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50) hang("write");
	endtask
	task automatic rd(input logic [5:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rd_q = rdata;
				resp_q = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50) hang("read");
	endtask
	// polls the complete flag with a bounded count of reads
	task automatic wait_flag();
		int n;
		for (n = 0; n < 100; n++)
		begin
			rd(A_CTRL);
			if (rd_q[7] === 1'b1) break;
		end
		if (n == 100) hang("flag");
	endtask
	task automatic chk_results(input int base, input int inc);
		int k;
		for (k = 0; k < 4; k++)
		begin
			rd(ra[k]);
			chk("result", rd_q, {24'h0, lv[base + k * inc]});
		end
	endtask
	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		error_cnt = 0;
		tests_run = 0;
		for (g = 0; g < 16; g++) lv[g] = {g[3:0], ~g[3:0]};
		lv[12] = 8'hFF;
		lv[13] = 8'h00;
		lv[14] = 8'h80;
		ra[0] = {2'b00, sarsc_pkg::ADDR_RESULT_1};
		ra[1] = {2'b00, sarsc_pkg::ADDR_RESULT_2};
		ra[2] = {2'b00, sarsc_pkg::ADDR_RESULT_3};
		ra[3] = sarsc_pkg::ADDR_RESULT_4;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_CTRL);
		chk("ctrl reset", rd_q, {24'h0, sarsc_pkg::CTRL_RESET});
		rd(A_OPT);
		chk("opt reset", rd_q, {24'h0, sarsc_pkg::OPTIONS_RESET});
		chk("pump off", {31'h0, charge_pump_en}, 32'h0);
		wr(A_OPT, 8'hFF);
		rd(A_OPT);
		chk("opt bit2", rd_q, 32'h0000_00FB);
		chk("clock rc", {31'h0, rc_clock_select}, 32'h1);
		wr(A_OPT, 8'h90); // bus clock here is well above the limit
		chk("clock bus", {31'h0, rc_clock_select}, 32'h0);
		chk("pump on", {31'h0, charge_pump_en}, 32'h1);
		repeat (15) @(posedge aclk);
		rd(A_STAT);
		chk("settled", rd_q, 32'h1);
		rd(6'h3C);
		chk("unmapped", {30'h0, resp_q}, {30'h0, sarsc_pkg::RESP_SLVERR});
		$display("test registers done");
		wr(A_CTRL, 8'h03);
		wait_flag();
		chk_results(3, 0);
		wr(A_CTRL, 8'h03);
		rd(A_CTRL);
		chk("flag cleared", rd_q, 32'h3);
		wait_flag();
		$display("test single channel done");
		// reserved group 2 is skipped; low select bits set on purpose
		for (g = 0; g < 4; g++)
		begin
			if (g != 2)
			begin
				wr(A_CTRL, {4'h1, g[1:0], 2'b01});
				wait_flag();
				chk_results(g * 4, 1);
			end
		end
		wr(ra[0], 8'h00);
		rd(ra[0]);
		chk("result ro", rd_q, {24'h0, lv[12]});
		$display("test group done");
		stop_mode <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(A_STAT);
		chk("stopped", rd_q, 32'h0);
		stop_mode <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(A_STAT);
		chk("exit delay", rd_q, 32'h0);
		repeat (40) @(posedge aclk);
		rd(A_STAT);
		chk("resumed", rd_q, 32'h1);
		// delay bit clear: the short hold is over by the same read point
		wr(A_OPT, 8'h80);
		stop_mode <= 1'b1;
		repeat (8) @(posedge aclk);
		stop_mode <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(A_STAT);
		chk("fast exit", rd_q, 32'h1);
		$display("test stop exit done");
		wr(A_CTRL, 8'h25);
		wait_flag();
		lv[5] <= 8'h3C;
		repeat (220) @(posedge aclk);
		chk_results(5, 0);
		$display("test scan done");
		final_report();
	end
endmodule
`default_nettype wire
